// file: rtl/cso_pkg.sv
package cso_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD = 38400;
  localparam int BIT_CLKS = CLK_HZ / BAUD;
  localparam int MS_CLKS = CLK_HZ / 1000;
  localparam int PWM_START_MS = 2;
  localparam int PWM_SPAN_MS = 1000;
  localparam int PWM_PERIOD_MS = 2000;
  localparam int UPDATE_MS = 5000;
  localparam int MCAL_MIN_MS = 600000;
  localparam int RANGE_DEF = 2000;
  localparam int RANGE_OPT = 5000;
  localparam int PPM_MAX_DEF = 5000;
  localparam int ALARM_ON_PPM = 1200;
  localparam int ALARM_OFF_PPM = 800;
  localparam int FRAME_LEN = 12;
  localparam int DIGITS = 6;
  localparam int RESP_LEN = 7;
  localparam logic [6:0] I2C_ADDR = 7'h31;
  localparam logic [7:0] CMD_READ = 8'h52;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_P = 8'h70;
  localparam logic [7:0] CH_M = 8'h6D;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] RSV_BYTE = 8'h00;
  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_ACK = 3'b010,
    I_WDAT = 3'b011,
    I_RDAT = 3'b100,
    I_RACK = 3'b101,
    I_RNEXT = 3'b110
  } cso_i2c_t;
endpackage : cso_pkg

// file: rtl/cso_uart_tx.sv
`timescale 1ns/1ns
module cso_uart_tx #(
  parameter int BIT_CLKS = cso_pkg::BIT_CLKS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic [7:0] data,
  output logic ready,
  output logic txd
);
  localparam int CW = $clog2(BIT_CLKS + 1);
  logic busy_r;
  logic [9:0] sh_r;
  logic [3:0] nbit_r;
  logic [CW-1:0] cnt_r;

  assign ready = !busy_r;

  // start, 8 data lsb first, one stop, no parity
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_r <= 1'b0;
      sh_r <= 10'h3FF;
      nbit_r <= 4'h0;
      cnt_r <= '0;
      txd <= 1'b1;
    end else if (!busy_r) begin
      txd <= 1'b1;
      if (go) begin
        busy_r <= 1'b1;
        sh_r <= {1'b1, data, 1'b0};
        nbit_r <= 4'h0;
        cnt_r <= '0;
      end
    end else begin
      txd <= sh_r[0];
      if (cnt_r == CW'(BIT_CLKS - 1)) begin
        cnt_r <= '0;
        sh_r <= {1'b1, sh_r[9:1]};
        nbit_r <= nbit_r + 4'h1;
        if (nbit_r == 4'h9) begin
          busy_r <= 1'b0;
        end
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule : cso_uart_tx

// file: rtl/cso_top.sv
`timescale 1ns/1ns
// How it works
// R1 - serial link 38400 baud, 8 data bits, no parity, one stop bit
// R2 - each report is 12 bytes, six decimal digit characters first, msd first
// R3 - then space, "ppm", carriage return, line feed
// R4 - leading zero digits are sent as spaces
// R5 - i2c slave only at 7-bit address 0x31, never starts a transfer
// R6 - address byte lsb is direction: 0x63 read, 0x62 write
// R7 - host writes 0x52 between start and stop to request a reading
// R8 - read returns config byte, two ppm bytes, four zero bytes
// R9 - host waits at least 1 ms between response byte reads
// R10 - pwm high time is 2 ms plus 1000 ms times ppm over range
// R11 - pwm period fixed at 2000 ms, low time is the rest
// R12 - pwm range 2000 ppm by default, 5000 ppm as build option
// R13 - alarm high at 1200 ppm or more, low at 800 or less, else hold
// R14 - shown concentration refreshes every 5 seconds
// R15 - outputs operate within 10 seconds of power-up
// R16 - reported range 400 to 5000 ppm, upper limit is an option; code clips only at PPM_MAX, values below 400 pass unchanged
// R17 - automatic baseline calibration on by default unless manual one runs
// R18 - manual calibration lasts at least 10 minutes once started
// R19 - manual calibration may be started by the control pin
// R20 - i2c ppm bytes are one unsigned value, msb first
// R21 - reset pin low returns line high, pwm low, alarm low
module cso_top #(
  parameter int MS_CLKS = cso_pkg::MS_CLKS,
  parameter int BIT_CLKS = cso_pkg::BIT_CLKS,
  parameter bit RANGE_WIDE = 1'b0,
  parameter int PPM_MAX = cso_pkg::PPM_MAX_DEF,
  parameter logic [7:0] CFG_BYTE = 8'h00
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ext_rst_n,
  input wire logic [13:0] co2_ppm,
  input wire logic manual_calibration_pin,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic uart_txd,
  output logic pwm_out,
  output logic alarm_out,
  output logic auto_baseline_calibration,
  output logic manual_calibration
);
  localparam int RANGE = RANGE_WIDE ? cso_pkg::RANGE_OPT : cso_pkg::RANGE_DEF;
  localparam int MW = $clog2(MS_CLKS + 1);

  // pin synchronisers
  logic [1:0] rstn_s_r, mcp_s_r, scl_s_r, sda_s_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rstn_s_r <= 2'h0;
      mcp_s_r <= 2'h0;
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
    end else begin
      rstn_s_r <= {rstn_s_r[0], ext_rst_n};
      mcp_s_r <= {mcp_s_r[0], manual_calibration_pin};
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
    end
  end
  logic rst;
  assign rst = sys_rst || !rstn_s_r[1]; // R21

  // millisecond enable
  logic [MW-1:0] div_r;
  logic ms_tick;
  assign ms_tick = (div_r == MW'(MS_CLKS - 1));
  always_ff @(posedge clk_sys) begin
    if (rst || ms_tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // 5 s refresh of shown value
  logic [12:0] upd_ms_r;
  logic upd_tick, valid_r;
  logic [13:0] shown_r, clip_ppm;
  assign upd_tick = ms_tick && (upd_ms_r == 13'(cso_pkg::UPDATE_MS - 1));
  assign clip_ppm = (co2_ppm > 14'(PPM_MAX)) ? 14'(PPM_MAX) : co2_ppm; // R16
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      upd_ms_r <= 13'h0000;
      shown_r <= 14'h0000;
      valid_r <= 1'b0;
    end else if (ms_tick) begin
      upd_ms_r <= upd_tick ? 13'h0000 : upd_ms_r + 13'h0001; // R14
      if (upd_tick) begin
        shown_r <= clip_ppm; // R14
        valid_r <= 1'b1; // R15
      end
    end
  end

  // alarm with hysteresis
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alarm_out <= 1'b0; // R21
    end else if (valid_r && shown_r >= 14'(cso_pkg::ALARM_ON_PPM)) begin
      alarm_out <= 1'b1; // R13
    end else if (shown_r <= 14'(cso_pkg::ALARM_OFF_PPM)) begin
      alarm_out <= 1'b0; // R13
    end
  end

  // pwm
  logic [10:0] pwm_ms_r, high_ms_r;
  logic [13:0] pwm_ppm;
  logic [23:0] prod;
  logic [10:0] high_nxt;
  assign pwm_ppm = (shown_r > 14'(RANGE)) ? 14'(RANGE) : shown_r; // R12
  assign prod = 24'(cso_pkg::PWM_SPAN_MS) * 24'(pwm_ppm);
  assign high_nxt = 11'(cso_pkg::PWM_START_MS) + 11'(prod / 24'(RANGE)); // R10
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwm_ms_r <= 11'h000;
      high_ms_r <= 11'h000;
    end else if (ms_tick) begin
      if (pwm_ms_r == 11'(cso_pkg::PWM_PERIOD_MS - 1)) begin
        pwm_ms_r <= 11'h000; // R11
        high_ms_r <= valid_r ? high_nxt : 11'h000; // R10
      end else begin
        pwm_ms_r <= pwm_ms_r + 11'h001;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwm_out <= 1'b0; // R21
    end else begin
      pwm_out <= (pwm_ms_r < high_ms_r); // R11
    end
  end

  // serial report
  function automatic logic [47:0] to_chars(input logic [13:0] v);
    logic [16:0] rem;
    logic [3:0] dig;
    logic lead;
    rem = 17'(v);
    lead = 1'b1;
    to_chars = '0;
    for (int i = 0; i < cso_pkg::DIGITS; i++) begin
      dig = 4'(rem / (17'(10) ** 17'(cso_pkg::DIGITS - 1 - i)) % 17'(10));
      if (dig != 4'h0 || i == cso_pkg::DIGITS - 1) begin
        lead = 1'b0;
      end
      to_chars[47 - 8 * i -: 8] = lead ? cso_pkg::CH_SP : (cso_pkg::CH_ZERO | 8'(dig)); // R4
    end
  endfunction : to_chars

  logic [47:0] chars_r;
  logic [3:0] frm_idx_r;
  logic sending_r, tx_ready, tx_go;
  logic [7:0] frm_byte;
  assign tx_go = sending_r && tx_ready;
  always_comb begin
    case (frm_idx_r) // R2 R3
      4'h6: frm_byte = cso_pkg::CH_SP;
      4'h7: frm_byte = cso_pkg::CH_P;
      4'h8: frm_byte = cso_pkg::CH_P;
      4'h9: frm_byte = cso_pkg::CH_M;
      4'hA: frm_byte = cso_pkg::CH_CR;
      4'hB: frm_byte = cso_pkg::CH_LF;
      default: frm_byte = chars_r[47 - 8 * frm_idx_r -: 8];
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chars_r <= '0;
      frm_idx_r <= 4'h0;
      sending_r <= 1'b0;
    end else if (upd_tick && !sending_r) begin
      chars_r <= to_chars(clip_ppm); // R2
      frm_idx_r <= 4'h0;
      sending_r <= 1'b1;
    end else if (tx_go) begin
      frm_idx_r <= frm_idx_r + 4'h1;
      if (frm_idx_r == 4'(cso_pkg::FRAME_LEN - 1)) begin
        sending_r <= 1'b0; // R2
      end
    end
  end

  cso_uart_tx #(.BIT_CLKS(BIT_CLKS)) u_tx ( // R1
    .clk_sys(clk_sys),
    .rst(rst),
    .go(tx_go),
    .data(frm_byte),
    .ready(tx_ready),
    .txd(uart_txd)
  );

  // manual / automatic calibration
  logic [19:0] mcal_ms_r;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      manual_calibration <= 1'b0;
      mcal_ms_r <= 20'h00000;
    end else if (!manual_calibration) begin
      if (mcp_s_r[1]) begin
        manual_calibration <= 1'b1; // R19
        mcal_ms_r <= 20'h00000;
      end
    end else begin
      if (ms_tick && mcal_ms_r != 20'(cso_pkg::MCAL_MIN_MS)) begin
        mcal_ms_r <= mcal_ms_r + 20'h00001;
      end
      if (mcal_ms_r == 20'(cso_pkg::MCAL_MIN_MS) && !mcp_s_r[1]) begin
        manual_calibration <= 1'b0; // R18
      end
    end
  end
  assign auto_baseline_calibration = !manual_calibration; // R17

  // i2c slave
  logic scl_q, sda_q, i_start, i_stop, scl_rise, scl_fall;
  cso_pkg::cso_i2c_t ist_r;
  logic [7:0] rx_r, tx_r;
  logic [2:0] bit_r, ridx_r;
  logic rw_r;
  logic [13:0] snap_r;
  logic [7:0] rx_full;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s_r[1];
      sda_q <= sda_s_r[1];
    end
  end
  assign i_start = scl_s_r[1] && sda_q && !sda_s_r[1];
  assign i_stop = scl_s_r[1] && !sda_q && sda_s_r[1];
  assign scl_rise = scl_s_r[1] && !scl_q;
  assign scl_fall = !scl_s_r[1] && scl_q;
  assign rx_full = {rx_r[6:0], sda_s_r[1]};
  assign sda_o = 1'b0;

  function automatic logic [7:0] resp(input logic [2:0] i, input logic [13:0] v);
    case (i) // R8 R20
      3'h0: resp = CFG_BYTE;
      3'h1: resp = 8'(v >> 8);
      3'h2: resp = v[7:0];
      default: resp = cso_pkg::RSV_BYTE;
    endcase
  endfunction : resp

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ist_r <= cso_pkg::I_IDLE;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      bit_r <= 3'h0;
      ridx_r <= 3'h0;
      rw_r <= 1'b0;
      snap_r <= 14'h0000;
      sda_oe <= 1'b0;
    end else if (i_start) begin
      ist_r <= cso_pkg::I_ADDR;
      bit_r <= 3'h0;
      sda_oe <= 1'b0;
    end else if (i_stop) begin
      ist_r <= cso_pkg::I_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (ist_r)
        cso_pkg::I_ADDR, cso_pkg::I_WDAT: begin
          if (scl_rise) begin
            rx_r <= rx_full;
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'h7) begin
              if (ist_r == cso_pkg::I_WDAT) begin
                if (rx_full == cso_pkg::CMD_READ) begin
                  snap_r <= shown_r; // R7
                end
                rw_r <= 1'b0;
                ist_r <= cso_pkg::I_ACK;
              end else if (rx_full[7:1] == cso_pkg::I2C_ADDR) begin // R5
                rw_r <= rx_full[0]; // R6
                ridx_r <= 3'h0;
                tx_r <= resp(3'h0, snap_r);
                ist_r <= cso_pkg::I_ACK;
              end else begin
                ist_r <= cso_pkg::I_IDLE;
              end
            end
          end
        end
        cso_pkg::I_ACK: begin
          if (scl_fall) begin
            if (!sda_oe) begin
              sda_oe <= 1'b1;
            end else if (rw_r) begin
              sda_oe <= !tx_r[7];
              bit_r <= 3'h0;
              ist_r <= cso_pkg::I_RDAT;
            end else begin
              sda_oe <= 1'b0;
              bit_r <= 3'h0;
              ist_r <= cso_pkg::I_WDAT;
            end
          end
        end
        cso_pkg::I_RDAT: begin
          if (scl_fall) begin
            bit_r <= bit_r + 3'h1;
            tx_r <= {tx_r[6:0], 1'b0};
            sda_oe <= (bit_r == 3'h7) ? 1'b0 : !tx_r[6];
            if (bit_r == 3'h7) begin
              ist_r <= cso_pkg::I_RACK;
            end
          end
        end
        cso_pkg::I_RACK: begin
          if (scl_rise) begin
            if (sda_s_r[1] || ridx_r == 3'(cso_pkg::RESP_LEN - 1)) begin
              ist_r <= cso_pkg::I_IDLE;
            end else begin
              ridx_r <= ridx_r + 3'h1;
              tx_r <= resp(ridx_r + 3'h1, snap_r); // R8
              ist_r <= cso_pkg::I_RNEXT;
            end
          end
        end
        cso_pkg::I_RNEXT: begin
          if (scl_fall) begin
            sda_oe <= !tx_r[7];
            bit_r <= 3'h0;
            ist_r <= cso_pkg::I_RDAT;
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking

  chk_reset_idle: assert property (rst |=> uart_txd && !pwm_out && !alarm_out) // R21
    else $error("outputs not idle after reset");
  chk_alarm_on: assert property (disable iff (rst)
    valid_r && shown_r >= 14'(cso_pkg::ALARM_ON_PPM) |=> alarm_out) // R13
    else $error("alarm not raised");
  chk_alarm_off: assert property (disable iff (rst)
    shown_r <= 14'(cso_pkg::ALARM_OFF_PPM) |=> !alarm_out) // R13
    else $error("alarm not cleared");
  chk_alarm_hold: assert property (disable iff (rst)
    shown_r > 14'(cso_pkg::ALARM_OFF_PPM) && shown_r < 14'(cso_pkg::ALARM_ON_PPM)
    && $stable(shown_r) |=> $stable(alarm_out)) // R13
    else $error("alarm changed between thresholds");
  chk_pwm_period: assert property (disable iff (rst)
    ms_tick && pwm_ms_r == 11'(cso_pkg::PWM_PERIOD_MS - 1) |=> pwm_ms_r == 11'h000) // R11
    else $error("pwm period wrong");
  chk_pwm_start: assert property (disable iff (rst)
    ms_tick && pwm_ms_r == 11'(cso_pkg::PWM_PERIOD_MS - 1) && valid_r |=> ##1 pwm_out) // R10
    else $error("pwm start portion missing");
  chk_frame_end: assert property (disable iff (rst)
    tx_go && frm_idx_r == 4'(cso_pkg::FRAME_LEN - 1) |=> !sending_r) // R2
    else $error("frame length wrong");
  chk_frame_tail: assert property (disable iff (rst)
    tx_go && frm_idx_r == 4'hA |-> frm_byte == cso_pkg::CH_CR ##2 !uart_txd) // R3
    else $error("frame tail wrong");
  chk_lead_blank: assert property (disable iff (rst)
    tx_go && frm_idx_r == 4'h0 |-> frm_byte != cso_pkg::CH_ZERO) // R4
    else $error("leading zero sent");
  chk_i2c_idle: assert property (disable iff (rst)
    ist_r == cso_pkg::I_IDLE |-> !sda_oe) // R5
    else $error("sda driven while idle");
  chk_mcal_min: assert property (disable iff (rst)
    manual_calibration && mcal_ms_r < 20'(cso_pkg::MCAL_MIN_MS) |=> manual_calibration) // R18
    else $error("manual calibration ended early");
  chk_refresh: assert property (disable iff (rst)
    upd_tick |=> shown_r == $past(clip_ppm) && valid_r) // R14
    else $error("shown value not refreshed");
endmodule : cso_top

// file: verif/cso_host_model.sv
`timescale 1ns/1ns
module cso_host_model #(
  parameter int BIT_CLKS = 8,
  parameter int PHASE = 8
) (
  input wire logic clk_sys,
  input wire logic uart_txd,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  logic [7:0] rx_q[$];
  time rx_t[$];
  int frame_errs = 0;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // serial receiver: start low, 8 bits lsb first, one stop bit high
  always begin : rx
    logic [7:0] b;
    @(negedge uart_txd);
    rx_t.push_back($time);
    repeat (BIT_CLKS / 2) @(posedge clk_sys);
    if (uart_txd !== 1'b0) frame_errs++;
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_sys);
      b[i] = uart_txd;
    end
    repeat (BIT_CLKS) @(posedge clk_sys);
    if (uart_txd !== 1'b1) frame_errs++;
    rx_q.push_back(b);
  end

  task automatic hold();
    repeat (PHASE) @(posedge clk_sys);
    #1;
  endtask : hold

  // clock stands high between transfers, data changes while clock low except for start and stop
  task automatic start();
    sda_low = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b1;
    hold();
    scl = 1'b0;
    hold();
  endtask : start

  task automatic stop();
    sda_low = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b0;
    hold();
  endtask : stop

  // one clock period is two phases: data set with clock low, sampled at end of high
  task automatic bit1(input logic v, output logic r);
    sda_low = ~v;
    hold();
    scl = 1'b1;
    hold();
    r = sda;
    scl = 1'b0;
  endtask : bit1

  // one byte msb first plus acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack_out);
    for (int i = 7; i >= 0; i--) bit1(tx[i], rx[i]);
    bit1(ack_in, ack_out);
    sda_low = 1'b0;
  endtask : xfer
endmodule : cso_host_model

// file: verif/co2_sensor_digital_outputs_tb_top.sv
`timescale 1ns/1ns
module co2_sensor_digital_outputs_tb_top;
  localparam int MS = 4;
  localparam int BC = 8;
  localparam logic [7:0] CFG = 8'hA5;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic ext_rst_n = 1'b0;
  logic [13:0] co2_ppm = 14'h4B0;
  logic man_pin = 1'b0;
  logic scl, sda, sda_low, sda_o, sda_oe, uart_txd, pwm_out, alarm_out, auto_cal, man_cal;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;

  // open drain wire with pull-up
  assign sda = ~((sda_oe & ~sda_o) | sda_low);

  initial forever #5 clk_sys = ~clk_sys;

  cso_top #(.MS_CLKS(MS), .BIT_CLKS(BC), .CFG_BYTE(CFG)) u_dut (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ext_rst_n(ext_rst_n),
    .co2_ppm(co2_ppm),
    .manual_calibration_pin(man_pin),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .uart_txd(uart_txd),
    .pwm_out(pwm_out),
    .alarm_out(alarm_out),
    .auto_baseline_calibration(auto_cal),
    .manual_calibration(man_cal)
  );

  cso_host_model #(.BIT_CLKS(BC), .PHASE(4)) u_host (
    .clk_sys(clk_sys),
    .uart_txd(uart_txd),
    .sda(sda),
    .scl(scl),
    .sda_low(sda_low)
  );

  task automatic summarize();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic chk32(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk32

  task automatic chk8(input logic [7:0] got, input logic [7:0] want);
    chk32({24'h000000, got}, {24'h000000, want});
  endtask : chk8

  task automatic chk1(input logic got, input logic want);
    chk32({31'h00000000, got}, {31'h00000000, want});
  endtask : chk1

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic check_frame(input int ppm);
    logic [7:0] e[12];
    int d;
    bit lead;
    lead = 1'b1;
    for (int i = 0; i < 6; i++) begin
      d = (ppm / (10 ** (5 - i))) % 10;
      if (d != 0 || i == 5) lead = 1'b0;
      e[i] = lead ? 8'h20 : 8'h30 + 8'(d);
    end
    e[6:11] = '{8'h20, 8'h70, 8'h70, 8'h6D, 8'h0D, 8'h0A};
    for (int k = 0; k < 25000 && u_host.rx_q.size() < 12; k++) step(1);
    chk32(32'(u_host.rx_q.size()), 32'h0000000C);
    for (int i = 0; i < 12; i++) chk8(u_host.rx_q.pop_front(), e[i]);
  endtask : check_frame

  task automatic check_pwm(input int ppm);
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    @(posedge pwm_out);
    #1;
    while (pwm_out === 1'b1) begin
      step(1);
      hi++;
    end
    while (pwm_out === 1'b0) begin
      step(1);
      lo++;
    end
    chk32(32'(hi), 32'((2 + 1000 * ppm / 2000) * MS));
    chk32(32'(hi + lo), 32'(2000 * MS));
  endtask : check_pwm

  task automatic i2c_read_check(input logic [15:0] ppm);
    logic [7:0] r;
    logic a;
    logic [7:0] want[7];
    want = '{CFG, ppm[15:8], ppm[7:0], 8'h00, 8'h00, 8'h00, 8'h00};
    u_host.start();
    u_host.xfer(8'h62, 1'b1, r, a);
    chk1(a, 1'b0);
    u_host.xfer(8'h52, 1'b1, r, a);
    chk1(a, 1'b0);
    u_host.stop();
    u_host.start();
    u_host.xfer(8'h63, 1'b1, r, a);
    chk1(a, 1'b0);
    for (int i = 0; i < 7; i++) begin
      step(MS);
      u_host.xfer(8'hFF, 1'b0, r, a);
      chk8(r, want[i]);
    end
    u_host.stop();
    u_host.start();
    u_host.xfer(8'h60, 1'b1, r, a);
    chk1(a, 1'b1);
    u_host.stop();
  endtask : i2c_read_check

  task automatic check_cal();
    man_pin = 1'b1;
    step(6);
    chk1(man_cal, 1'b1);
    chk1(auto_cal, 1'b0);
    man_pin = 1'b0;
    step(20);
    chk1(man_cal, 1'b1);
    ext_rst_n = 1'b0;
    step(5);
    chk1(man_cal, 1'b0);
    chk1(auto_cal, 1'b1);
    chk1(uart_txd, 1'b1);
    chk1(pwm_out, 1'b0);
    chk1(alarm_out, 1'b0);
  endtask : check_cal

  initial begin
    step(8);
    chk1(uart_txd, 1'b1);
    chk1(pwm_out, 1'b0);
    chk1(alarm_out, 1'b0);
    chk1(auto_cal, 1'b1);
    sys_rst = 1'b0;
    ext_rst_n = 1'b1;
    check_frame(1200);
    chk1(alarm_out, 1'b1);
    check_pwm(1200);
    i2c_read_check(16'h04B0);
    co2_ppm = 14'h3E8;
    check_frame(1000);
    chk1(alarm_out, 1'b1);
    co2_ppm = 14'h320;
    check_frame(800);
    chk1(alarm_out, 1'b0);
    chk32(32'(u_host.rx_t[24] - u_host.rx_t[12]), 32'(5000 * MS * 10));
    chk32(32'(u_host.frame_errs), 32'h00000000);
    check_cal();
    summarize();
  end
endmodule : co2_sensor_digital_outputs_tb_top
